// >>> src/ufl_cfg.v
// mode register zero bank with baud group decode and fifo interrupt levels
// Summary of operation
// - decode baud select 000 normal, 001 extended one, 100 extended two
// - watchdog enable is shared with wake/char register bits 7:6
// - 8-byte receive thresholds 1, 3, 6, 8 bytes for codes 00..11
// - 256-byte receive thresholds 1, 128, 192, 256 bytes for codes 00..11
// - 8-byte transmit thresholds all empty, 4, 6, 1 empty places
// - 256-byte transmit thresholds 256, 128, 192, 1 empty places
// - depth bit picks 8 or 256 byte fifos and threshold table
// - receive level code is mode zero bit 6 over mode one bit 6
// - transmit level code is mode zero bits 5:4, reset 00
`timescale 1ns/1ps
module ufl_cfg (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // register bus
  input wire bus_wr,
  input wire bus_rd,
  input wire [1:0] bus_sel,
  input wire [7:0] bus_wdata,
  output reg [7:0] bus_rdata,
  // fifo state from the uart core
  input wire [8:0] rx_fill,
  input wire [8:0] tx_empty,
  // outputs to the uart core
  output reg fifo_deep,
  output reg [1:0] baud_group,
  output reg baud_bad,
  output reg wdog_enable,
  output reg rx_irq_req,
  output reg tx_irq_req
);
`include "ufl_consts.vh"
  // stored fields; the watchdog bit is one flop seen at two addresses
  reg [6:0] mode_zero_low;
  reg wdog;
  reg [7:0] mode_register_one;
  reg [5:0] wake_char_low;
  // next values
  reg [6:0] next_mode_zero_low;
  reg next_wdog;
  reg [7:0] next_mode_one;
  reg [5:0] next_wake_char_low;
  reg [7:0] next_rdata;
  reg [1:0] next_group;
  reg next_bad;
  // compare lanes
  localparam LANE_RX = 0;
  localparam LANE_TX = 1;
  localparam LANES = 2;
  // reset images, register views and decoded strobes
  wire [7:0] mode_zero_init;
  wire [7:0] mode_one_init;
  wire [7:0] wake_char_init;
  wire [7:0] mode_register_zero;
  wire [7:0] wake_char_enable_register;
  wire [2:0] baud_select;
  wire depth_select;
  wire [1:0] rx_level_select;
  wire [1:0] tx_level_select;
  wire wr_mode_zero;
  wire wr_mode_one;
  wire wr_wake_char;
  // per-direction compare lanes: lane 0 receive, lane 1 transmit
  wire [3:0] lane_code;
  wire [17:0] lane_count;
  wire [1:0] lane_hit;

  assign mode_zero_init = `UFL_MODE_ZERO_RESET;
  assign mode_one_init = `UFL_MODE_ONE_RESET;
  assign wake_char_init = `UFL_WAKE_CHAR_RESET;
  assign mode_register_zero = {wdog, mode_zero_low};
  assign wake_char_enable_register = {wdog, wdog, wake_char_low};
  assign baud_select = mode_register_zero[`UFL_BAUD_HI:`UFL_BAUD_LO];
  assign depth_select = mode_register_zero[`UFL_DEPTH_BIT];
  assign rx_level_select = {mode_register_zero[`UFL_RX_LVL_BIT],
                            mode_register_one[`UFL_RX_LVL_BIT]};
  assign tx_level_select = mode_register_zero[`UFL_TX_LVL_HI:`UFL_TX_LVL_LO];
  assign wr_mode_zero = bus_wr && (bus_sel == `UFL_SEL_MODE_ZERO);
  assign wr_mode_one = bus_wr && (bus_sel == `UFL_SEL_MODE_ONE);
  assign wr_wake_char = bus_wr && (bus_sel == `UFL_SEL_WAKE_CHAR);
  assign lane_code = {tx_level_select, rx_level_select};
  assign lane_count = {tx_empty, rx_fill};

  // next register values; the unmapped select changes nothing
  always @* begin
    next_mode_zero_low = mode_zero_low;
    next_wdog = wdog;
    next_mode_one = mode_register_one;
    next_wake_char_low = wake_char_low;
    if (wr_mode_zero) begin
      next_mode_zero_low = bus_wdata[6:0];
      next_wdog = bus_wdata[`UFL_WDOG_BIT];
    end
    if (wr_mode_one) begin
      next_mode_one = bus_wdata;
    end
    if (wr_wake_char) begin
      next_wake_char_low = bus_wdata[`UFL_WC_LOW_HI:0];
      // either copy of the watchdog bit sets the shared control
      next_wdog = bus_wdata[`UFL_WC_WDOG_HI] | bus_wdata[`UFL_WC_WDOG_LO];
    end
  end

  // mode register zero, bits 6:0
  always @(posedge ref_clk) begin
    if (rst) begin
      mode_zero_low <= mode_zero_init[6:0];
    end else begin
      mode_zero_low <= next_mode_zero_low;
    end
  end

  // shared watchdog enable, mode zero bit 7 and wake/char bits 7:6
  always @(posedge ref_clk) begin
    if (rst) begin
      wdog <= mode_zero_init[`UFL_WDOG_BIT];
    end else begin
      wdog <= next_wdog;
    end
  end

  // mode register one, stored whole
  always @(posedge ref_clk) begin
    if (rst) begin
      mode_register_one <= mode_one_init;
    end else begin
      mode_register_one <= next_mode_one;
    end
  end

  // wake/char register, bits 5:0
  always @(posedge ref_clk) begin
    if (rst) begin
      wake_char_low <= wake_char_init[`UFL_WC_LOW_HI:0];
    end else begin
      wake_char_low <= next_wake_char_low;
    end
  end

  // read data select; the unmapped select reads as zero
  always @* begin
    next_rdata = bus_rdata;
    if (bus_rd) begin
      case (bus_sel)
        `UFL_SEL_MODE_ZERO: next_rdata = mode_register_zero;
        `UFL_SEL_MODE_ONE: next_rdata = mode_register_one;
        `UFL_SEL_WAKE_CHAR: next_rdata = wake_char_enable_register;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // read data is registered one cycle after the strobe and stands until the next read
  always @(posedge ref_clk) begin
    if (rst) begin
      bus_rdata <= 8'h00;
    end else begin
      bus_rdata <= next_rdata;
    end
  end

  // baud group decode; reserved bit and other codes flagged, normal group used
  always @* begin
    next_group = `UFL_GRP_NORMAL;
    next_bad = 1'b0;
    case (baud_select)
      `UFL_BAUD_NORMAL: next_group = `UFL_GRP_NORMAL;
      `UFL_BAUD_EXT1: next_group = `UFL_GRP_EXT1;
      `UFL_BAUD_EXT2: next_group = `UFL_GRP_EXT2;
      default: next_bad = 1'b1;
    endcase
  end

  // one threshold compare per fifo direction
  genvar lane;
  generate
    for (lane = 0; lane < LANES; lane = lane + 1) begin : lane_cmp
      ufl_threshold ufl_threshold_inst (
        .deep(depth_select),
        .tx_mode(lane == LANE_TX),
        .code(lane_code[2*lane +: 2]),
        .count(lane_count[9*lane +: 9]),
        .hit(lane_hit[lane])
      );
    end
  endgenerate

  // baud group outputs to the baud generator
  always @(posedge ref_clk) begin
    if (rst) begin
      baud_group <= `UFL_GRP_NORMAL;
      baud_bad <= 1'b0;
    end else begin
      baud_group <= next_group;
      baud_bad <= next_bad;
    end
  end

  // fifo depth and watchdog outputs to the uart core
  always @(posedge ref_clk) begin
    if (rst) begin
      fifo_deep <= 1'b0;
      wdog_enable <= 1'b0;
    end else begin
      fifo_deep <= depth_select;
      wdog_enable <= wdog;
    end
  end

  // requests follow the counts every cycle, so they drop as soon as a level is missed
  always @(posedge ref_clk) begin
    if (rst) begin
      rx_irq_req <= 1'b0;
      tx_irq_req <= 1'b0;
    end else begin
      rx_irq_req <= lane_hit[LANE_RX];
      tx_irq_req <= lane_hit[LANE_TX];
    end
  end
endmodule // ufl_cfg

// >>> src/ufl_consts.vh
// constants for the uart fifo level and baud group configuration block
`ifndef UFL_CONSTS_VH
`define UFL_CONSTS_VH
// register select codes on the parallel bus
`define UFL_SEL_MODE_ZERO 2'h0
`define UFL_SEL_MODE_ONE 2'h1
`define UFL_SEL_WAKE_CHAR 2'h2
// reset values
`define UFL_MODE_ZERO_RESET 8'h00
`define UFL_MODE_ONE_RESET 8'h00
`define UFL_WAKE_CHAR_RESET 8'h00
// field positions
`define UFL_WDOG_BIT 7
`define UFL_RX_LVL_BIT 6
`define UFL_TX_LVL_HI 5
`define UFL_TX_LVL_LO 4
`define UFL_DEPTH_BIT 3
`define UFL_BAUD_HI 2
`define UFL_BAUD_RSVD 1
`define UFL_BAUD_LO 0
`define UFL_WC_WDOG_HI 7
`define UFL_WC_WDOG_LO 6
`define UFL_WC_LOW_HI 5
// baud group encodings
`define UFL_BAUD_NORMAL 3'h0
`define UFL_BAUD_EXT1 3'h1
`define UFL_BAUD_EXT2 3'h4
`define UFL_GRP_NORMAL 2'h0
`define UFL_GRP_EXT1 2'h1
`define UFL_GRP_EXT2 2'h2
// fill thresholds, 9-bit counts
`define UFL_S_LVL0 9'h001
`define UFL_S_LVL1 9'h003
`define UFL_S_LVL2 9'h006
`define UFL_S_FULL 9'h008
`define UFL_S_TX1 9'h004
`define UFL_L_LVL1 9'h080
`define UFL_L_LVL2 9'h0c0
`define UFL_L_FULL 9'h100
`endif

// >>> src/ufl_threshold.v
// fill or empty count threshold compare for one fifo direction
`timescale 1ns/1ps
module ufl_threshold (
  // selection
  input wire deep,
  input wire tx_mode,
  input wire [1:0] code,
  // counts
  input wire [8:0] count,
  // result
  output reg hit
);
`include "ufl_consts.vh"
  reg [8:0] limit;
  always @* begin
    limit = `UFL_S_LVL0;
    case ({tx_mode, deep, code})
      4'h0: limit = `UFL_S_LVL0;
      4'h1: limit = `UFL_S_LVL1;
      4'h2: limit = `UFL_S_LVL2;
      4'h3: limit = `UFL_S_FULL;
      4'h4: limit = `UFL_S_LVL0;
      4'h5: limit = `UFL_L_LVL1;
      4'h6: limit = `UFL_L_LVL2;
      4'h7: limit = `UFL_L_FULL;
      4'h8: limit = `UFL_S_FULL;
      4'h9: limit = `UFL_S_TX1;
      4'ha: limit = `UFL_S_LVL2;
      4'hb: limit = `UFL_S_LVL0;
      4'hc: limit = `UFL_L_FULL;
      4'hd: limit = `UFL_L_LVL1;
      4'he: limit = `UFL_L_LVL2;
      4'hf: limit = `UFL_S_LVL0;
      default: limit = `UFL_S_LVL0;
    endcase
    hit = (count >= limit);
  end
endmodule // ufl_threshold

// >>> tb/tb.sv
// testbench for the mode register zero bank
`timescale 1ns/1ps
module tb;
  reg ref_clk = 1'h0;
  reg rst = 1'h1;
  reg [8:0] rx_fill = 9'h0;
  reg [8:0] tx_empty = 9'h0;
  wire bus_wr, bus_rd, fifo_deep, baud_bad, wdog_enable, rx_irq_req, tx_irq_req;
  wire [1:0] bus_sel, baud_group;
  wire [7:0] bus_wdata, bus_rdata;
  integer error_cnt = 0;
  integer num_checks = 0;
  reg [7:0] v;
  // expected threshold indexed by {deep, transmit, code}
  function [8:0] th;
    input [3:0] idx;
    begin
      case (idx)
        4'h0: th = 9'h001;
        4'h1: th = 9'h003;
        4'h2: th = 9'h006;
        4'h3: th = 9'h008;
        4'h4: th = 9'h008;
        4'h5: th = 9'h004;
        4'h6: th = 9'h006;
        4'h7: th = 9'h001;
        4'h8: th = 9'h001;
        4'h9: th = 9'h080;
        4'ha: th = 9'h0c0;
        4'hb: th = 9'h100;
        4'hc: th = 9'h100;
        4'hd: th = 9'h080;
        4'he: th = 9'h0c0;
        default: th = 9'h001;
      endcase
    end
  endfunction
  ufl_host ufl_host_inst (.ref_clk, .bus_rdata, .bus_wr, .bus_rd, .bus_sel, .bus_wdata);
  ufl_cfg ufl_cfg_inst (.ref_clk, .rst, .bus_wr, .bus_rd, .bus_sel, .bus_wdata, .bus_rdata,
    .rx_fill, .tx_empty, .fifo_deep, .baud_group, .baud_bad, .wdog_enable, .rx_irq_req,
    .tx_irq_req);
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  task chk(input [8:0] g, input [8:0] e);
    num_checks = num_checks + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task cnt(input [8:0] r, input [8:0] t);
    @(posedge ref_clk);
    rx_fill <= r;
    tx_empty <= t;
    @(posedge ref_clk);
    #1;
  endtask
  task t_reset;
    ufl_host_inst.rd(2'h0, v);
    chk(v, 8'h00);
    cnt(9'h0, 9'h8);
    chk({rx_irq_req, tx_irq_req}, 2'h1);
    cnt(9'h1, 9'h7);
    chk({rx_irq_req, tx_irq_req}, 2'h2);
    $display("reset test done");
  endtask
  task t_baud;
    integer i;
    for (i = 0; i < 3; i = i + 1) begin
      ufl_host_inst.wr(2'h0, {5'h00, i[1], 1'h0, i[0]});
      // the group output flop follows the register one edge later
      @(posedge ref_clk);
      #1 chk({baud_bad, baud_group}, i);
    end
    $display("baud test done");
  endtask
  task t_wdog;
    ufl_host_inst.wr(2'h2, 8'h40);
    ufl_host_inst.rd(2'h2, v);
    chk(v, 8'hc0);
    // mode zero still holds baud code 100 from the baud test
    ufl_host_inst.rd(2'h0, v);
    chk({wdog_enable, v}, 9'h184);
    ufl_host_inst.wr(2'h0, 8'h00);
    ufl_host_inst.rd(2'h2, v);
    chk({wdog_enable, v}, 9'h0);
    $display("watchdog test done");
  endtask
  task t_lvl;
    integer k;
    reg [8:0] r;
    reg [8:0] t;
    for (k = 0; k < 8; k = k + 1) begin
      r = th({k[2], 1'h0, k[1:0]});
      t = th({k[2], 1'h1, k[1:0]});
      ufl_host_inst.wr(2'h1, {1'h0, k[0], 6'h00});
      ufl_host_inst.wr(2'h0, {1'h0, k[1], k[1:0], k[2], 3'h0});
      cnt(r, t);
      chk({fifo_deep, rx_irq_req, tx_irq_req}, {k[2], 2'h3});
      cnt(r - 9'h1, t - 9'h1);
      chk({rx_irq_req, tx_irq_req}, 2'h0);
    end
    $display("level test done");
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    print_verdict;
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'h0;
    t_reset;
    t_baud;
    t_wdog;
    t_lvl;
    print_verdict;
  end
endmodule // tb

// >>> tb/ufl_cfg_properties.sv
// assertions on the mode register zero bank ports
`timescale 1ns/1ps
module ufl_cfg_properties (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // register bus
  input wire bus_wr,
  input wire [1:0] bus_sel,
  input wire [7:0] bus_wdata,
  // fifo counts
  input wire [8:0] rx_fill,
  input wire [8:0] tx_empty,
  // block outputs
  input wire fifo_deep,
  input wire [1:0] baud_group,
  input wire baud_bad,
  input wire wdog_enable,
  input wire rx_irq_req,
  input wire tx_irq_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // register lands at the write edge, output flop follows one edge later
  wire w0 = bus_wr && bus_sel == 2'h0;
  wire w2 = bus_wr && bus_sel == 2'h2;
  wire wgood = w0 && (bus_wdata[2:0] == 3'h0 || bus_wdata[2:0] == 3'h1 ||
    bus_wdata[2:0] == 3'h4);
  depth_sel_a: assert property (w0 |-> ##2 fifo_deep == $past(bus_wdata[3], 2))
    else $error("fifo depth output mismatch");
  baud_norm_a: assert property (w0 && bus_wdata[2:0] == 3'h0 |-> ##2 baud_group == 2'h0)
    else $error("normal baud group mismatch");
  baud_ext1_a: assert property (w0 && bus_wdata[2:0] == 3'h1 |-> ##2 baud_group == 2'h1)
    else $error("extended one baud group mismatch");
  baud_ext2_a: assert property (w0 && bus_wdata[2:0] == 3'h4 |-> ##2 baud_group == 2'h2)
    else $error("extended two baud group mismatch");
  baud_good_a: assert property (wgood |-> ##2 !baud_bad)
    else $error("defined baud code flagged");
  wdog_share_a: assert property (w2 |-> ##2 wdog_enable == |$past(bus_wdata[7:6], 2))
    else $error("watchdog from wake register mismatch");
  wdog_zero_a: assert property (w0 |-> ##2 wdog_enable == $past(bus_wdata[7], 2))
    else $error("watchdog from mode zero mismatch");
  rx_none_a: assert property (rx_fill == 9'h0 |=> !rx_irq_req)
    else $error("receive request with empty fifo");
  rx_full_a: assert property (rx_fill == 9'h100 |=> rx_irq_req)
    else $error("no receive request with full fifo");
  tx_none_a: assert property (tx_empty == 9'h0 |=> !tx_irq_req)
    else $error("transmit request with no space");
  tx_all_a: assert property (tx_empty == 9'h100 |=> tx_irq_req)
    else $error("no transmit request with all space");
endmodule // ufl_cfg_properties
bind ufl_cfg ufl_cfg_properties ufl_cfg_properties_inst (.ref_clk, .rst, .bus_wr, .bus_sel,
  .bus_wdata, .rx_fill, .tx_empty, .fifo_deep, .baud_group, .baud_bad, .wdog_enable,
  .rx_irq_req, .tx_irq_req);

// >>> tb/ufl_host.sv
// host model driving the register bus
`timescale 1ns/1ps
module ufl_host (
  // clock
  input wire ref_clk,
  // register bus
  input wire [7:0] bus_rdata,
  output reg bus_wr,
  output reg bus_rd,
  output reg [1:0] bus_sel,
  output reg [7:0] bus_wdata
);
  initial begin
    bus_wr = 1'h0;
    bus_rd = 1'h0;
    bus_sel = 2'h0;
    bus_wdata = 8'h00;
  end
  task wr(input [1:0] s, input [7:0] d);
    @(posedge ref_clk);
    bus_wr <= 1'h1;
    bus_sel <= s;
    bus_wdata <= (s == 2'h0) ? d & 8'hfd : d;
    @(posedge ref_clk);
    bus_wr <= 1'h0;
    bus_wdata <= ~bus_wdata;
  endtask
  task rd(input [1:0] s, output [7:0] d);
    @(posedge ref_clk);
    bus_rd <= 1'h1;
    bus_sel <= s;
    @(posedge ref_clk);
    bus_rd <= 1'h0;
    #1 d = bus_rdata;
  endtask
endmodule // ufl_host
